/* File: hw/ied_exec_seq.sv */
/*
 * Instruction execution sequencer: decodes fetched words, keeps the
 * accumulator and arithmetic flags, issues file writes, program
 * counter requests, timer prescaler clears and forced idle cycles.
 * Assumes one fetched word per i_fetch_valid pulse, and that
 * i_file_rdata holds the register addressed by the word's low byte
 * in that same cycle.
 */
// Summary of operation
// - Port read-modify-write uses pin levels, not latch
// - Timer zero write clears assigned prescaler
// - Branch taken or return: idle second cycle; goto and call none
// - Unclaimed second word executes as idle
// - Every word decodes legally, none trap
// - Add literal to accumulator, all five flags
`timescale 1ns/1ps
`include "ied_consts.svh"

module ied_exec_seq (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Fetch stream
  input wire logic i_fetch_valid,
  input wire logic [15:0] i_fetch_word,
  // Operand sources
  input wire logic [7:0] i_file_rdata,
  input wire logic [7:0] i_port_b_pins,
  input wire logic i_presc_on_timer,
  // Results
  output logic [7:0] o_acc,
  output ied_pkg::ied_flags_t o_flags,
  output ied_pkg::ied_file_wr_t o_file_wr,
  output ied_pkg::ied_pc_req_t o_pc_req,
  output logic o_presc_clr,
  output logic o_idle_cycle
);
  import ied_pkg::*;

  // ----------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------
  logic [7:0] pins_s1;
  logic [7:0] pins_s2;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pins_s1 <= 8'h00;
      pins_s2 <= 8'h00;
    end else begin
      pins_s1 <= i_port_b_pins;
      pins_s2 <= pins_s1;
    end
  end

  // ----------------------------------------------------------
  // Decode
  // ----------------------------------------------------------
  ied_state_t state;
  ied_state_t next_state;
  logic [7:0] first_byte;
  logic [7:0] next_first_byte;
  logic word2_is_ptr;
  logic next_word2_is_ptr;
  logic [7:0] next_acc;
  ied_flags_t next_flags;
  ied_file_wr_t next_file_wr;
  ied_pc_req_t next_pc_req;
  logic next_presc_clr;
  logic next_idle_cycle;

  logic [7:0] f_addr;
  logic dest_file;
  logic [7:0] src;
  logic [7:0] add_b;
  logic [7:0] sum;
  ied_flags_t add_flags;
  logic is_add_lit;
  logic cond_true;

  assign f_addr = i_fetch_word[7:0];
  assign dest_file = i_fetch_word[`IED_DEST_BIT];
  assign is_add_lit = (i_fetch_word[15:8] == `IED_OP8_ADD_LIT);
  assign src = (f_addr == `IED_ADDR_IO_PORT_B_DATA) ? pins_s2 :
               i_file_rdata;
  assign add_b = is_add_lit ? i_fetch_word[7:0] : src;

  ied_adder u_adder (
    .i_a(o_acc),
    .i_b(add_b),
    .o_sum(sum),
    .o_flags(add_flags)
  );

  always_comb begin
    case (i_fetch_word[10:8])
      3'h0: cond_true = o_flags.z;
      3'h1: cond_true = !o_flags.z;
      3'h2: cond_true = o_flags.c;
      3'h3: cond_true = !o_flags.c;
      3'h4: cond_true = o_flags.ov;
      3'h5: cond_true = !o_flags.ov;
      3'h6: cond_true = o_flags.n;
      default: cond_true = !o_flags.n;
    endcase
  end

  always_comb begin
    next_state = state;
    next_first_byte = first_byte;
    next_word2_is_ptr = word2_is_ptr;
    next_acc = o_acc;
    next_flags = o_flags;
    next_file_wr = '0;
    next_pc_req = '0;
    next_presc_clr = 1'b0;
    next_idle_cycle = 1'b0;
    case (state)
      IED_ST_EXEC: begin
        if (!i_fetch_valid) begin
          next_state = state;
        end else if (i_fetch_word[15:12] == `IED_OP4_SECOND_WORD) begin
          next_idle_cycle = 1'b1;
        end else if (is_add_lit) begin
          next_acc = sum;
          next_flags = add_flags;
        end else if (i_fetch_word[15:10] == `IED_OP6_ADD_FILE) begin
          next_flags = add_flags;
          if (dest_file) begin
            next_file_wr = '{we: 1'b1, addr: f_addr, data: sum};
          end else begin
            next_acc = sum;
          end
        end else if (i_fetch_word[15:10] == `IED_OP6_MOVE_FILE) begin
          next_flags.z = (src == 8'h00);
          next_flags.n = src[7];
          if (dest_file) begin
            next_file_wr = '{we: 1'b1, addr: f_addr, data: src};
          end else begin
            next_acc = src;
          end
        end else if (i_fetch_word[15:9] == `IED_OP7_MOVE_TO_FILE) begin
          next_file_wr = '{we: 1'b1, addr: f_addr, data: o_acc};
        end else if (i_fetch_word[15:11] == `IED_OP5_COND_BRANCH) begin
          if (cond_true) begin
            next_pc_req = '{load: 1'b1, kind: IED_PC_REL,
                            arg: {{12{i_fetch_word[7]}}, i_fetch_word[7:0]}};
            next_state = IED_ST_FLUSH;
          end
        end else if (i_fetch_word[15:12] == `IED_OP4_REL_BRANCH) begin
          next_pc_req = '{load: 1'b1, kind: IED_PC_REL,
                          arg: {{9{i_fetch_word[10]}}, i_fetch_word[10:0]}};
          next_state = IED_ST_FLUSH;
        end else if (i_fetch_word[15:8] == `IED_OP8_GOTO ||
                     i_fetch_word[15:9] == `IED_OP7_CALL ||
                     i_fetch_word[15:8] == `IED_OP8_LOAD_PTR) begin
          next_first_byte = i_fetch_word[7:0];
          next_word2_is_ptr = (i_fetch_word[15:8] == `IED_OP8_LOAD_PTR);
          next_state = IED_ST_WORD2;
        end else if (i_fetch_word[15:1] == `IED_OP15_RETURN ||
                     i_fetch_word[15:1] == `IED_OP15_RET_INT ||
                     i_fetch_word[15:8] == `IED_OP8_RET_LIT) begin
          if (i_fetch_word[15:8] == `IED_OP8_RET_LIT) begin
            next_acc = i_fetch_word[7:0];
          end
          next_pc_req = '{load: 1'b1, kind: IED_PC_RET, arg: 20'h00000};
          next_state = IED_ST_FLUSH;
        end
        if (next_file_wr.we && f_addr == `IED_ADDR_TIMER_ZERO_COUNT &&
            i_presc_on_timer) begin
          next_presc_clr = 1'b1;
        end
      end
      IED_ST_WORD2: begin
        if (i_fetch_valid) begin
          // Pointer load consumes the word outside this block
          if (!word2_is_ptr) begin
            next_pc_req = '{load: 1'b1, kind: IED_PC_JUMP,
                            arg: {i_fetch_word[11:0], first_byte}};
          end
          next_state = IED_ST_EXEC;
        end
      end
      IED_ST_FLUSH: begin
        if (i_fetch_valid) begin
          next_idle_cycle = 1'b1;
          next_state = IED_ST_EXEC;
        end
      end
      default: begin
        next_state = IED_ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= IED_ST_EXEC;
      first_byte <= 8'h00;
      word2_is_ptr <= 1'b0;
      o_acc <= `IED_ACC_RST;
      o_flags <= `IED_FLAGS_RST;
      o_file_wr <= '0;
      o_pc_req <= '0;
      o_presc_clr <= 1'b0;
      o_idle_cycle <= 1'b0;
    end else begin
      state <= next_state;
      first_byte <= next_first_byte;
      word2_is_ptr <= next_word2_is_ptr;
      o_acc <= next_acc;
      o_flags <= next_flags;
      o_file_wr <= next_file_wr;
      o_pc_req <= next_pc_req;
      o_presc_clr <= next_presc_clr;
      o_idle_cycle <= next_idle_cycle;
    end
  end

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  logic take;
  assign take = i_fetch_valid && state == IED_ST_EXEC;

  sequence s_port_move;
    take && i_fetch_word[15:10] == `IED_OP6_MOVE_FILE && dest_file &&
      f_addr == `IED_ADDR_IO_PORT_B_DATA;
  endsequence
  property p_port_pins;
    s_port_move |=> o_file_wr.we && o_file_wr.data == $past(pins_s2);
  endproperty
  a_port_pins: assert property (p_port_pins)
    else $error("port write-back not from pins");

  property p_presc;
    o_presc_clr |-> $past(take) && o_file_wr.we &&
      o_file_wr.addr == `IED_ADDR_TIMER_ZERO_COUNT && $past(i_presc_on_timer);
  endproperty
  a_presc: assert property (p_presc)
    else $error("prescaler clear without timer write");

  sequence s_jump;
    take && i_fetch_word[15:12] == `IED_OP4_REL_BRANCH;
  endsequence
  sequence s_flush_take;
    state == IED_ST_FLUSH && i_fetch_valid;
  endsequence
  property p_two_cycle;
    s_jump |=> o_pc_req.load && state == IED_ST_FLUSH && !o_idle_cycle;
  endproperty
  a_two_cycle: assert property (p_two_cycle)
    else $error("jump not followed by idle cycle");

  property p_flush_idle;
    s_flush_take |=>
      o_idle_cycle && !o_file_wr.we && !o_pc_req.load &&
      state == IED_ST_EXEC && o_acc == $past(o_acc);
  endproperty
  a_flush_idle: assert property (p_flush_idle)
    else $error("flushed word had an effect");

  property p_stray_word;
    take && i_fetch_word[15:12] == `IED_OP4_SECOND_WORD |=>
      o_idle_cycle && !o_file_wr.we && !o_pc_req.load &&
      o_acc == $past(o_acc) && o_flags == $past(o_flags);
  endproperty
  a_stray_word: assert property (p_stray_word)
    else $error("stray second word not idle");

  property p_legal_state;
    take && i_fetch_word[15:8] != `IED_OP8_GOTO &&
      i_fetch_word[15:9] != `IED_OP7_CALL &&
      i_fetch_word[15:8] != `IED_OP8_LOAD_PTR |=>
      state == IED_ST_EXEC || state == IED_ST_FLUSH;
  endproperty
  a_legal_state: assert property (p_legal_state)
    else $error("unclaimed word left sequencer waiting");

  property p_add_lit;
    take && is_add_lit |=>
      o_acc == 8'($past(o_acc) + $past(i_fetch_word[7:0])) &&
      o_flags.z == (o_acc == 8'h00) && !o_file_wr.we;
  endproperty
  a_add_lit: assert property (p_add_lit)
    else $error("add literal result wrong");

  property p_add_file;
    take && i_fetch_word[15:10] == `IED_OP6_ADD_FILE |=>
      (o_file_wr.we == $past(dest_file)) &&
      ($past(dest_file) ? (o_acc == $past(o_acc) &&
        o_file_wr.data == 8'($past(o_acc) + $past(src))) :
        o_acc == 8'($past(o_acc) + $past(src)));
  endproperty
  a_add_file: assert property (p_add_file)
    else $error("add to file destination wrong");

endmodule // ied_exec_seq

/* File: hw/ied_consts.svh */
/*
 * Constants of the instruction execution sequencer: opcode fields,
 * field positions, special file addresses and reset values.
 * Assumes inclusion by bare name from the package and the modules.
 */
`ifndef IED_CONSTS_SVH
`define IED_CONSTS_SVH

// ------------------------------------------------------------
// Opcode fields, compared against the top bits of a word
// ------------------------------------------------------------
`define IED_OP8_ADD_LIT 8'h0f
`define IED_OP8_RET_LIT 8'h0c
`define IED_OP6_ADD_FILE 6'h09
`define IED_OP6_MOVE_FILE 6'h14
`define IED_OP7_MOVE_TO_FILE 7'h37
`define IED_OP5_COND_BRANCH 5'h1c
`define IED_OP4_REL_BRANCH 4'hd
`define IED_OP8_GOTO 8'hef
`define IED_OP7_CALL 7'h76
`define IED_OP8_LOAD_PTR 8'hee
`define IED_OP4_SECOND_WORD 4'hf
`define IED_OP15_RETURN 15'h0009
`define IED_OP15_RET_INT 15'h0008

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define IED_DEST_BIT 9

// ------------------------------------------------------------
// Special file addresses (low byte of the file operand)
// ------------------------------------------------------------
`define IED_ADDR_IO_PORT_B_DATA 8'h81
`define IED_ADDR_TIMER_ZERO_COUNT 8'hd6

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define IED_ACC_RST 8'h00
`define IED_FLAGS_RST 5'h00

`endif

/* File: hw/ied_pkg.sv */
/*
 * Types shared by the instruction execution sequencer modules.
 * Assumes the constants header is on the include path.
 */
`include "ied_consts.svh"

package ied_pkg;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } ied_flags_t;

  typedef enum logic [1:0] {
    IED_ST_EXEC = 2'b00,
    IED_ST_WORD2 = 2'b01,
    IED_ST_FLUSH = 2'b10
  } ied_state_t;

  typedef enum logic [1:0] {
    IED_PC_JUMP = 2'b00,
    IED_PC_REL = 2'b01,
    IED_PC_RET = 2'b10
  } ied_pc_kind_t;

  typedef struct packed {
    logic load;
    ied_pc_kind_t kind;
    logic [19:0] arg;
  } ied_pc_req_t;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } ied_file_wr_t;

endpackage

/* File: hw/ied_adder.sv */
/*
 * Eight-bit adder with the full set of arithmetic flags.
 * Assumes purely combinational use inside the sequencer.
 */
`timescale 1ns/1ps

module ied_adder (
  // Operands
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_b,
  // Result
  output logic [7:0] o_sum,
  output ied_pkg::ied_flags_t o_flags
);
  import ied_pkg::*;

  logic [8:0] full;
  logic [4:0] low;

  always_comb begin
    full = {1'b0, i_a} + {1'b0, i_b};
    low = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
    o_sum = full[7:0];
    o_flags.c = full[8];
    o_flags.dc = low[4];
    o_flags.z = (full[7:0] == 8'h00);
    o_flags.n = full[7];
    // Signed overflow: like-signed operands, differently signed result
    o_flags.ov = (i_a[7] == i_b[7]) && (full[7] != i_a[7]);
  end

endmodule // ied_adder

/* File: bench/test_instr_exec_sequencing.sv */
/*
 * Self-checking bench for the instruction execution sequencer.
 * Assumes the package and the constants header are compiled first.
 */
`timescale 1ns/1ps
`include "ied_consts.svh"

module test_instr_exec_sequencing;
  import ied_pkg::*;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam logic [15:0] mv_acc_w = {`IED_OP7_MOVE_TO_FILE, 1'b0, 8'h40};
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_fetch_valid = 1'b0;
  logic [15:0] i_fetch_word = 16'h0000;
  logic [7:0] i_file_rdata = 8'h00;
  logic [7:0] i_port_b_pins = 8'h00;
  logic i_presc_on_timer = 1'b0;
  logic [7:0] o_acc;
  ied_flags_t o_flags;
  ied_file_wr_t o_file_wr;
  ied_pc_req_t o_pc_req;
  logic o_presc_clr;
  logic o_idle_cycle;
  int fails = 0;
  int cmp_count = 0;
  logic [7:0] acc_mdl = 8'h00;
  logic [4:0] flg_mdl = 5'h00;

  always #10 i_clk_sys = ~i_clk_sys;

  ied_exec_seq dut_u (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_fetch_valid(i_fetch_valid),
    .i_fetch_word(i_fetch_word),
    .i_file_rdata(i_file_rdata),
    .i_port_b_pins(i_port_b_pins),
    .i_presc_on_timer(i_presc_on_timer),
    .o_acc(o_acc),
    .o_flags(o_flags),
    .o_file_wr(o_file_wr),
    .o_pc_req(o_pc_req),
    .o_presc_clr(o_presc_clr),
    .o_idle_cycle(o_idle_cycle)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Outputs land at the taking edge, so look just after it
  task automatic step(input logic [15:0] w, input logic [7:0] rd);
    i_fetch_valid = 1'b1;
    i_fetch_word = w;
    i_file_rdata = rd;
    @(posedge i_clk_sys);
    #1;
  endtask

  task automatic gap(input int n);
    i_fetch_valid = 1'b0;
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  // Returns {n, ov, z, dc, c, sum}
  function automatic logic [12:0] ref_add(input logic [7:0] a, b);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00,
            h[4], s[8], s[7:0]};
  endfunction

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_add_lit();
    logic [7:0] ks [5] = '{8'h10, 8'h15, 8'hdb, 8'h80, 8'h80};
    foreach (ks[i]) begin
      {flg_mdl, acc_mdl} = ref_add(acc_mdl, ks[i]);
      step({`IED_OP8_ADD_LIT, ks[i]}, 8'h00);
      chk(o_acc, acc_mdl);
      chk(o_flags, flg_mdl);
    end
    $display("test add literal done");
  endtask

  // Destination bit and prescaler assignment in all four mixes
  task automatic t_add_file();
    logic [12:0] r;
    logic [7:0] rd;
    for (int i = 0; i < 4; i++) begin
      rd = 8'h3c + i[7:0];
      r = ref_add(acc_mdl, rd);
      i_presc_on_timer = i[0];
      step({`IED_OP6_ADD_FILE, i[1], 1'b0, `IED_ADDR_TIMER_ZERO_COUNT}, rd);
      if (!i[1])
        acc_mdl = r[7:0];
      flg_mdl = r[12:8];
      chk(o_file_wr.we, i[1]);
      if (i[1])
        chk({o_file_wr.addr, o_file_wr.data}, {8'hd6, r[7:0]});
      chk(o_acc, acc_mdl);
      chk(o_flags, flg_mdl);
      chk(o_presc_clr, i[1] & i[0]);
    end
    step({`IED_OP6_ADD_FILE, 2'b10, 8'h40}, 8'h05);
    chk(o_presc_clr, 1'b0);
    chk(o_file_wr.addr, 8'h40);
    for (int p = 1; p >= 0; p--) begin
      i_presc_on_timer = p[0];
      step({`IED_OP7_MOVE_TO_FILE, 1'b0, `IED_ADDR_TIMER_ZERO_COUNT}, 8'h00);
      chk({o_presc_clr, o_file_wr}, {p[0], 1'b1, 8'hd6, acc_mdl});
    end
    $display("test add to file done");
  endtask

  task automatic t_port_rmw();
    logic [12:0] r;
    i_port_b_pins = 8'h5a;
    gap(3);
    step({`IED_OP6_MOVE_FILE, 2'b10, `IED_ADDR_IO_PORT_B_DATA}, 8'hff);
    chk(o_file_wr, {1'b1, 8'h81, 8'h5a});
    step({`IED_OP6_MOVE_FILE, 2'b10, 8'h40}, 8'ha5);
    chk(o_file_wr, {1'b1, 8'h40, 8'ha5});
    r = ref_add(acc_mdl, 8'h5a);
    step({`IED_OP6_ADD_FILE, 2'b10, `IED_ADDR_IO_PORT_B_DATA}, 8'hff);
    chk(o_file_wr, {1'b1, 8'h81, r[7:0]});
    step({`IED_OP6_MOVE_FILE, 2'b00, `IED_ADDR_IO_PORT_B_DATA}, 8'hff);
    acc_mdl = 8'h5a;
    chk({o_acc, o_flags.n, o_flags.z}, {acc_mdl, 2'b00});
    gap(1);
    $display("test port read-modify-write done");
  endtask

  // Each condition code, with the word behind it as probe
  // Four flag mixes so that every flag is seen at both levels
  task automatic t_cond_branch();
    logic tk;
    logic [3:0] sel;
    logic [7:0] ks [4] = '{8'h80, 8'h27, 8'h7f, 8'h80};
    foreach (ks[k]) begin
      {flg_mdl, acc_mdl} = ref_add(acc_mdl, ks[k]);
      step({`IED_OP8_ADD_LIT, ks[k]}, 8'h00);
      chk(o_flags, flg_mdl);
      sel = {flg_mdl[4], flg_mdl[3], flg_mdl[0], flg_mdl[2]};
      for (int c = 0; c < 8; c++) begin
        tk = c[0] ^ sel[c[2:1]];
        step({`IED_OP5_COND_BRANCH, c[2:0], 8'hfe}, 8'h00);
        chk(o_pc_req.load, tk);
        if (tk)
          chk({o_pc_req.kind, o_pc_req.arg}, {IED_PC_REL, 20'hffffe});
        step(mv_acc_w, 8'h00);
        chk(o_idle_cycle, tk);
        chk(o_file_wr.we, !tk);
      end
    end
    $display("test conditional branch done");
  endtask

  task automatic t_flow();
    step({`IED_OP4_REL_BRANCH, 12'h005}, 8'h00);
    chk(o_pc_req, {1'b1, IED_PC_REL, 20'h00005});
    step(mv_acc_w, 8'h00);
    chk({o_idle_cycle, o_file_wr.we}, 2'b10);
    step({`IED_OP15_RETURN, 1'b0}, 8'h00);
    chk(o_pc_req, {1'b1, IED_PC_RET, 20'h00000});
    step(mv_acc_w, 8'h00);
    chk({o_idle_cycle, o_file_wr.we}, 2'b10);
    step({`IED_OP15_RET_INT, 1'b1}, 8'h00);
    chk(o_pc_req, {1'b1, IED_PC_RET, 20'h00000});
    step(mv_acc_w, 8'h00);
    chk({o_idle_cycle, o_file_wr.we}, 2'b10);
    step({`IED_OP8_RET_LIT, 8'h5c}, 8'h00);
    acc_mdl = 8'h5c;
    chk({o_pc_req, o_acc}, {1'b1, IED_PC_RET, 20'h00000, acc_mdl});
    step(mv_acc_w, 8'h00);
    chk({o_idle_cycle, o_file_wr.we, o_acc}, {2'b10, acc_mdl});
    // Backward relative branch, gap held inside the flush
    step({`IED_OP4_REL_BRANCH, 12'hffe}, 8'h00);
    chk(o_pc_req, {1'b1, IED_PC_REL, 20'hffffe});
    gap(2);
    step(mv_acc_w, 8'h00);
    chk({o_idle_cycle, o_file_wr.we}, 2'b10);
    for (int i = 0; i < 2; i++) begin
      step(i ? {`IED_OP7_CALL, 9'h012} : {`IED_OP8_GOTO, 8'h12}, 8'h00);
      chk(o_pc_req.load, 1'b0);
      step(16'hf345, 8'h00);
      chk(o_pc_req, {1'b1, IED_PC_JUMP, 20'h34512});
      step(mv_acc_w, 8'h00);
      chk({o_idle_cycle, o_file_wr.we}, 2'b01);
    end
    step({`IED_OP8_LOAD_PTR, 8'h05}, 8'h00);
    step(16'hf0ab, 8'h00);
    chk({o_pc_req.load, o_file_wr.we, o_acc}, {2'b00, acc_mdl});
    step(16'hf123, 8'h00);
    chk({o_pc_req.load, o_file_wr.we, o_presc_clr}, 3'b000);
    chk({o_idle_cycle, o_acc, o_flags}, {1'b1, acc_mdl, flg_mdl});
    gap(1);
    $display("test program flow done");
  endtask

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Whole run needs about 120 cycles
  initial begin
    repeat (3000) @(posedge i_clk_sys);
    fails++;
    conclude();
  end

  initial begin
    repeat (10) @(posedge i_clk_sys);
    #1;
    i_rst_n = 1'b1;
    t_add_lit();
    t_add_file();
    t_port_rmw();
    t_cond_branch();
    t_flow();
    conclude();
  end

endmodule // test_instr_exec_sequencing
